/* File: logic/spcr_regs.sv */
// Serial port control, identifier and preset profile registers.
// Assumes a serial engine that presents decoded byte reads and writes,
// one-cycle write strobes, and strap pins stable while straps are taken.
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Bit value one asserts each control function
// - Order bit clear: MSB first, address steps down
// - Order bit set: LSB first, address steps up
// - Restore bit reloads registers from selected profile
// - Hardware reset keeps all register values
// - Drive bit: zero normal, one reduced, profile default
// - Read target bit picks live or buffered registers
// - Update bit pulses once and clears itself
// - Identifier bytes ignore writes
// - Identifier MSB at lowest address
// - Profile read returns last loaded index
// - Profile write selects one of sixty-four
// - Profile write reloads all profile-defaulted registers
// - Power-up profile comes from strap pins
module spcr_regs
   import spcr_pkg::*;
#(
   parameter int          ADDR_W         = 16,
   parameter logic [31:0] PART_IDENT     = 32'h5a5a_0001,  // Arbitrary value
   parameter logic [63:0] DRIVE_DEFAULTS = 64'h0000_0000_0000_0000
) (
   input  wire logic                      clk_in,             // 40 MHz clock
   input  wire logic                      rst_n_in,           // Sync reset, low
   input  wire logic [ADDR_W-1:0]         addr_in,            // Register address
   input  wire logic                      wr_in,              // Write strobe
   input  wire logic [7:0]                wdata_in,           // Write data
   input  wire logic                      rd_in,              // Read strobe
   input  wire logic                      buf_rd_valid_in,    // Buffered copy hit
   input  wire logic [7:0]                buf_rd_data_in,     // Buffered copy data
   input  wire logic [SPCR_PROFILE_W-1:0] strap_profile_in,   // Strap pin index
   output logic      [7:0]                rdata_out,          // Read data
   output logic      [ADDR_W-1:0]         next_addr_out,      // Next byte address
   output logic                           lsb_first_out,      // Bit-order mode
   output logic                           reduce_drive_out,   // Reduced pin drive
   output logic                           read_buffered_out,  // Read target
   output logic                           hw_reset_out,       // Core hardware reset
   output logic                           io_update_out,      // Update pulse
   output logic                           profile_load_out,   // Reload pulse
   output logic      [SPCR_PROFILE_W-1:0] profile_out         // Loaded profile
);
   // ****************************************
   // Elaboration checks
   // ****************************************
   initial begin
      if (ADDR_W < 4) $error("ADDR_W too small for the register map");
   end

   // ****************************************
   // Decode helpers
   // ****************************************
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      hit = (a == ADDR_W'(ofs));
   endfunction

   spcr_state_t state;
   spcr_state_t next_state;
   logic [SPCR_PROFILE_W-1:0] pending_profile;
   logic        rom_drive;
   logic        lsb_first;
   logic        reduce_drive;
   logic        read_buffered;
   logic        hw_reset;
   logic        io_update;
   logic        profile_load;
   logic [SPCR_PROFILE_W-1:0] profile;
   logic        wr_cfg;
   logic        wr_rst;
   logic        wr_upd;
   logic        wr_prof;
   logic        restore_req;

   assign wr_cfg  = wr_in && hit(addr_in, SPCR_OFS_SERIAL_PORT_CONFIG);
   assign wr_rst  = wr_in && hit(addr_in, SPCR_OFS_RESET_AND_READ_TARGET);
   assign wr_upd  = wr_in && hit(addr_in, SPCR_OFS_UPDATE_STROBE);
   assign wr_prof = wr_in && hit(addr_in, SPCR_OFS_PRESET_PROFILE_SELECT);
   // Restore reloads from the profile already selected
   assign restore_req = wr_cfg && wdata_in[SPCR_BIT_SOFT_RESTORE];

   // ****************************************
   // Leaf instances
   // ****************************************
   spcr_addr_step #(
      .ADDR_W        (ADDR_W)
   ) u_step (
      .addr_in       (addr_in),
      .lsb_first_in  (lsb_first),
      .next_addr_out (next_addr_out)
   );

   spcr_profile_rom #(
      .DRIVE_DEFAULTS   (DRIVE_DEFAULTS)
   ) u_rom (
      .index_in         (pending_profile),
      .reduce_drive_out (rom_drive)
   );

   // ****************************************
   // Load sequencer
   // ****************************************
   // Strap is taken one clock after reset release, never under reset
   always_comb begin
      next_state = state;
      case (state)
         SPCR_ST_STRAP: next_state = SPCR_ST_LOAD;
         SPCR_ST_LOAD:  next_state = SPCR_ST_IDLE;
         SPCR_ST_IDLE: begin
            if (wr_prof || restore_req) begin
               next_state = SPCR_ST_LOAD;
            end
         end
         default:       next_state = SPCR_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         state <= SPCR_ST_STRAP;
      end else begin
         state <= next_state;
      end
   end

   // Index to be loaded: strap at power-up, host write otherwise
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         pending_profile <= '0;
      end else if (state == SPCR_ST_STRAP) begin
         pending_profile <= strap_profile_in;
      end else if (state == SPCR_ST_IDLE && wr_prof) begin
         pending_profile <= wdata_in[SPCR_PROFILE_W-1:0];
      end
   end

   // Loaded index changes only once the load lands
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         profile <= '0;
      end else if (state == SPCR_ST_LOAD) begin
         profile <= pending_profile;
      end
   end

   // One-cycle pulse tells the other banks to take profile defaults
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         profile_load <= 1'b0;
      end else begin
         profile_load <= (state == SPCR_ST_LOAD);
      end
   end

   // ****************************************
   // Control registers
   // ****************************************
   // Bit order; restore and profile loads leave it alone
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         lsb_first <= SPCR_RST_SERIAL_PORT_CONFIG[SPCR_BIT_LSB_FIRST];
      end else if (wr_cfg) begin
         lsb_first <= wdata_in[SPCR_BIT_LSB_FIRST];
      end
   end

   // Drive strength is profile-defaulted; a load overrides a host write
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         reduce_drive <= 1'b0;
      end else if (state == SPCR_ST_LOAD) begin
         reduce_drive <= rom_drive;
      end else if (wr_rst) begin
         reduce_drive <= wdata_in[SPCR_BIT_REDUCE_DRIVE];
      end
   end

   // Hardware reset stays until host writes zero; registers untouched
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         hw_reset      <= SPCR_RST_RESET_AND_READ[SPCR_BIT_HW_RESET];
         read_buffered <= SPCR_RST_RESET_AND_READ[SPCR_BIT_READ_BUFFERED];
      end else if (wr_rst) begin
         hw_reset      <= wdata_in[SPCR_BIT_HW_RESET];
         read_buffered <= wdata_in[SPCR_BIT_READ_BUFFERED];
      end
   end

   // Self-clearing update: one pulse, reads back as zero
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         io_update <= 1'b0;
      end else begin
         io_update <= wr_upd && wdata_in[SPCR_BIT_IO_UPDATE];
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   // Buffered copies live in other banks; a buffered hit with read target set wins at every address
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         rdata_out <= SPCR_UNMAPPED_READ;
      end else if (rd_in) begin
         if (read_buffered && buf_rd_valid_in) begin
            rdata_out <= buf_rd_data_in;
         end else if (hit(addr_in, SPCR_OFS_SERIAL_PORT_CONFIG)) begin
            rdata_out <= {1'b0, lsb_first, 6'h00} & SPCR_MASK_CONFIG;
         end else if (hit(addr_in, SPCR_OFS_RESET_AND_READ_TARGET)) begin
            rdata_out <= {3'h0, hw_reset, 2'h0, reduce_drive, read_buffered}
                         & SPCR_MASK_RESET_READ;
         end else if (hit(addr_in, SPCR_OFS_IDENTIFIER_BYTE_3)) begin
            rdata_out <= PART_IDENT[31:24];
         end else if (hit(addr_in, SPCR_OFS_IDENTIFIER_BYTE_2)) begin
            rdata_out <= PART_IDENT[23:16];
         end else if (hit(addr_in, SPCR_OFS_IDENTIFIER_BYTE_1)) begin
            rdata_out <= PART_IDENT[15:8];
         end else if (hit(addr_in, SPCR_OFS_IDENTIFIER_BYTE_0)) begin
            rdata_out <= PART_IDENT[7:0];
         end else if (hit(addr_in, SPCR_OFS_PRESET_PROFILE_SELECT)) begin
            rdata_out <= {2'h0, profile} & SPCR_MASK_PROFILE;
         end else begin
            rdata_out <= SPCR_UNMAPPED_READ;
         end
      end
   end

   assign lsb_first_out     = lsb_first;
   assign reduce_drive_out  = reduce_drive;
   assign read_buffered_out = read_buffered;
   assign hw_reset_out      = hw_reset;
   assign io_update_out     = io_update;
   assign profile_load_out  = profile_load;
   assign profile_out       = profile;

   // ****************************************
   // Assertions
   // ****************************************
   sequence s_prof_write;
      (state == SPCR_ST_IDLE) && wr_prof;
   endsequence
   sequence s_load_done;
      profile_load ##0 (profile == $past(pending_profile));
   endsequence

   chk_profile_load_seq: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_prof_write |=> (state == SPCR_ST_LOAD) ##1 s_load_done)
      else $error("profile write did not reload");
   chk_profile_index: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      s_prof_write |-> ##2 (profile == $past(wdata_in[5:0], 2)))
      else $error("loaded profile index wrong");
   chk_update_pulse: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !(wr_upd && wdata_in[SPCR_BIT_IO_UPDATE]) |=> !io_update)
      else $error("update pulse did not clear");
   chk_update_cause: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      io_update |-> $past(wr_upd) && $past(wdata_in[0]))
      else $error("update pulse without write");
   chk_hwreset_hold: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (hw_reset && !wr_rst && !wr_cfg) |=> hw_reset && ($stable(lsb_first)))
      else $error("hardware reset did not hold");
   chk_order_write: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      wr_cfg |=> (lsb_first == $past(wdata_in[6])))
      else $error("bit order not stored");
   chk_restore_load: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      ((state == SPCR_ST_IDLE) && restore_req && !wr_prof) |-> ##2 profile_load
         ##0 $stable(profile))
      else $error("restore did not reload same profile");
   chk_ident_read: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && !read_buffered && hit(addr_in, SPCR_OFS_IDENTIFIER_BYTE_3))
         |=> (rdata_out == PART_IDENT[31:24]))
      else $error("identifier high byte wrong");
   chk_read_target: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && read_buffered && buf_rd_valid_in) |=> (rdata_out == $past(buf_rd_data_in)))
      else $error("buffered read not served");
   chk_strap_load: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state == SPCR_ST_STRAP) |-> ##2 (profile == $past(strap_profile_in, 2)))
      else $error("strap profile not loaded");

   // Address stepping follows the order bit in both directions
   chk_addr_step_up: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      lsb_first |-> (next_addr_out == addr_in + ADDR_W'(1)))
      else $error("address did not step up");
   chk_addr_step_down: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !lsb_first |-> (next_addr_out == addr_in - ADDR_W'(1)))
      else $error("address did not step down");
   // Restore and profile loads must leave the order bit alone
   chk_order_hold: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      !wr_cfg |=> $stable(lsb_first))
      else $error("bit order changed without write");
   chk_drive_write: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (wr_rst && (state != SPCR_ST_LOAD)) |=> (reduce_drive == $past(wdata_in[1])))
      else $error("drive strength not stored");
   chk_drive_load: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state == SPCR_ST_LOAD) |=> (reduce_drive == $past(rom_drive)))
      else $error("drive default not loaded");
   chk_reset_fields: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      wr_rst |=> (hw_reset == $past(wdata_in[SPCR_BIT_HW_RESET]))
         && (read_buffered == $past(wdata_in[SPCR_BIT_READ_BUFFERED])))
      else $error("reset or read target not stored");
   chk_load_pulse: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      profile_load |=> !profile_load)
      else $error("load pulse longer than one cycle");
   chk_profile_hold: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (state != SPCR_ST_LOAD) |=> $stable(profile))
      else $error("profile index changed without load");
   chk_profile_read: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && !(read_buffered && buf_rd_valid_in)
         && hit(addr_in, SPCR_OFS_PRESET_PROFILE_SELECT))
         |=> (rdata_out == {2'h0, $past(profile)}))
      else $error("profile read wrong");
   chk_ident_low: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && !read_buffered && hit(addr_in, SPCR_OFS_IDENTIFIER_BYTE_0))
         |=> (rdata_out == PART_IDENT[7:0]))
      else $error("identifier low byte wrong");
   chk_strobe_readback: assert property (
      @(posedge clk_in) disable iff (!rst_n_in)
      (rd_in && !read_buffered && hit(addr_in, SPCR_OFS_UPDATE_STROBE))
         |=> (rdata_out == 8'h00))
      else $error("update strobe did not read zero");
endmodule
`default_nettype wire

/* File: include/spcr_pkg.sv */
// Package for the serial port control and profile register bank.
// Assumes byte-wide registers reached through a byte-level register port.
package spcr_pkg;
   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [7:0] SPCR_OFS_SERIAL_PORT_CONFIG    = 8'h00;
   localparam logic [7:0] SPCR_OFS_RESET_AND_READ_TARGET = 8'h04;
   localparam logic [7:0] SPCR_OFS_UPDATE_STROBE         = 8'h05;
   localparam logic [7:0] SPCR_OFS_IDENTIFIER_BYTE_3     = 8'h0a;
   localparam logic [7:0] SPCR_OFS_IDENTIFIER_BYTE_2     = 8'h0b;
   localparam logic [7:0] SPCR_OFS_IDENTIFIER_BYTE_1     = 8'h0c;
   localparam logic [7:0] SPCR_OFS_IDENTIFIER_BYTE_0     = 8'h0d;
   localparam logic [7:0] SPCR_OFS_PRESET_PROFILE_SELECT = 8'h0e;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int SPCR_BIT_LSB_FIRST     = 6;
   localparam int SPCR_BIT_SOFT_RESTORE  = 5;
   localparam int SPCR_BIT_HW_RESET      = 4;
   localparam int SPCR_BIT_REDUCE_DRIVE  = 1;
   localparam int SPCR_BIT_READ_BUFFERED = 0;
   localparam int SPCR_BIT_IO_UPDATE     = 0;
   localparam int SPCR_PROFILE_W         = 6;

   // ****************************************
   // Reset values and read masks
   // ****************************************
   localparam logic [7:0] SPCR_RST_SERIAL_PORT_CONFIG = 8'h00;
   localparam logic [7:0] SPCR_RST_RESET_AND_READ     = 8'h00;
   localparam logic [7:0] SPCR_MASK_CONFIG            = 8'h40;
   localparam logic [7:0] SPCR_MASK_RESET_READ        = 8'h13;
   localparam logic [7:0] SPCR_MASK_PROFILE           = 8'h3f;
   localparam logic [7:0] SPCR_UNMAPPED_READ          = 8'h00;

   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [1:0] {
      SPCR_ST_IDLE    = 2'b00,
      SPCR_ST_STRAP   = 2'b01,
      SPCR_ST_LOAD    = 2'b10
   } spcr_state_t;
endpackage

/* File: logic/spcr_addr_step.sv */
// Next register address for multibyte serial transfers.
// Assumes the serial engine asks for one step after each byte.
`timescale 1ns/1ps
`default_nettype none
module spcr_addr_step
   import spcr_pkg::*;
#(
   parameter int ADDR_W = 16
) (
   input  wire logic [ADDR_W-1:0] addr_in,       // Current byte address
   input  wire logic              lsb_first_in,  // Bit-order control
   output logic      [ADDR_W-1:0] next_addr_out  // Address of next byte
);
   initial begin
      if (ADDR_W < 4) $error("ADDR_W too small for the register map");
   end

   // Down in MSB-first mode, up in LSB-first mode; wraps at the ends
   always_comb begin
      if (lsb_first_in) begin
         next_addr_out = addr_in + {{(ADDR_W-1){1'b0}}, 1'b1};
      end else begin
         next_addr_out = addr_in - {{(ADDR_W-1){1'b0}}, 1'b1};
      end
   end
endmodule
`default_nettype wire

/* File: logic/spcr_profile_rom.sv */
// Preset profile table: default drive-strength bit per profile index.
// Assumes the rest of each profile lives beside the other register banks.
`timescale 1ns/1ps
`default_nettype none
module spcr_profile_rom
   import spcr_pkg::*;
#(
   parameter logic [63:0] DRIVE_DEFAULTS = 64'h0000_0000_0000_0000
) (
   input  wire logic [SPCR_PROFILE_W-1:0] index_in,        // Profile index
   output logic                           reduce_drive_out  // Drive default
);
   // Constant lookup, no file read
   always_comb begin
      reduce_drive_out = DRIVE_DEFAULTS[index_in];
   end
endmodule
`default_nettype wire

/* File: bench/spcr_host_model.sv */
// Host model: serial engine byte port plus the bank holding buffered copies.
// Assumes the register bank samples its port on the rising edge of clk_in.
`timescale 1ns/1ps
`default_nettype none
module spcr_host_model #(
   parameter logic [15:0] BUF_ADDR = 16'h0100,
   parameter logic [7:0]  BUF_DATA = 8'ha5
) (
   input  wire logic        clk_in,        // Register port clock
   input  wire logic [7:0]  rdata_in,      // Read data from the bank
   output logic      [15:0] addr_out,      // Byte address
   output logic             wr_out,        // Write strobe
   output logic      [7:0]  wdata_out,     // Write data
   output logic             rd_out,        // Read strobe
   output logic             buf_valid_out, // Buffered copy hit
   output logic      [7:0]  buf_data_out   // Buffered copy data
);
   // ****************************************
   // Port state and buffered bank
   // ****************************************
   logic [7:0] churn = 8'h00;

   // Port idles with strobes low from time zero
   initial begin
      addr_out = 16'h0000;
      wr_out = 1'b0;
      wdata_out = 8'h00;
      rd_out = 1'b0;
   end

   // Data of a miss changes every cycle so a stale byte never passes
   always @(posedge clk_in) begin
      churn <= churn + 8'h3b;
   end
   assign buf_valid_out = (addr_out == BUF_ADDR);
   assign buf_data_out  = buf_valid_out ? BUF_DATA : churn;

   // ****************************************
   // Byte transfers, one strobe cycle each
   // ****************************************
   // Each byte carries its own address; the engine walks addresses
   task automatic wr_byte(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      wdata_out = d;
      wr_out = 1'b1;
      @(negedge clk_in);
      wr_out = 1'b0;
      wdata_out = ~d;
   endtask

   // Read data is taken one cycle after the strobe edge
   task automatic rd_byte(input logic [15:0] a, output logic [7:0] d);
      @(negedge clk_in);
      addr_out = a;
      rd_out = 1'b1;
      @(negedge clk_in);
      rd_out = 1'b0;
      d = rdata_in;
   endtask
endmodule
`default_nettype wire

/* File: bench/spcr_regs_tb.sv */
// Self-checking bench for the control, identifier and profile registers.
// Assumes the host model drives the byte port on falling edges.
`timescale 1ns/1ps
`default_nettype none
module spcr_regs_tb;
   import spcr_pkg::*;
   // ****************************************
   // Setup
   // ****************************************
   localparam logic [31:0] IDENT = 32'h1234_abcd;          // Arbitrary value
   localparam logic [63:0] DRIVE = 64'h8000_0400_0000_0021;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic [5:0]  strap = 6'h03;
   logic [15:0] addr, next_addr;
   logic [7:0]  wdata, rdata, bdata, d;
   logic        wr, rd, bvalid, lsb, drv, rbuf, hwr, upd, load;
   logic [5:0]  prof;
   int          num_errors = 0;
   int          n_tests = 0;

   // 40 MHz clock
   always #12.5 clk_in = ~clk_in;

   spcr_regs #(.ADDR_W(16), .PART_IDENT(IDENT), .DRIVE_DEFAULTS(DRIVE)) spcr_regs_i (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .addr_in(addr), .wr_in(wr),
      .wdata_in(wdata), .rd_in(rd), .buf_rd_valid_in(bvalid), .buf_rd_data_in(bdata),
      .strap_profile_in(strap), .rdata_out(rdata), .next_addr_out(next_addr),
      .lsb_first_out(lsb), .reduce_drive_out(drv), .read_buffered_out(rbuf),
      .hw_reset_out(hwr), .io_update_out(upd), .profile_load_out(load),
      .profile_out(prof));

   spcr_host_model spcr_host_model_i (
      .clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wr_out(wr),
      .wdata_out(wdata), .rd_out(rd), .buf_valid_out(bvalid), .buf_data_out(bdata));

   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Reset for six cycles, then let the strap capture and load finish
   task automatic do_reset();
      rst_n_in = 1'b0;
      repeat (6) @(negedge clk_in);
      rst_n_in = 1'b1;
      repeat (4) @(negedge clk_in);
   endtask

   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      spcr_host_model_i.rd_byte(a, d);
      chk_val(16'(d), 16'(exp));
   endtask

   task automatic report_and_stop();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Watchdog: the tests need well under a thousand cycles
   initial begin
      #(25 * 5000);
      num_errors++;
      report_and_stop();
   end

   // ****************************************
   // Tests
   // ****************************************
   initial begin
      do_reset();
      chk_val(16'(prof), 16'h0003);
      chk_bit(drv, DRIVE[3]);
      rd_chk(16'h000e, 8'h03);
      // Identifier bytes, then writes that must not stick
      for (int i = 0; i < 4; i++) begin
         rd_chk(16'h000a + 16'(i), IDENT[31-8*i -: 8]);
         spcr_host_model_i.wr_byte(16'h000a + 16'(i), 8'hff);
         rd_chk(16'h000a + 16'(i), IDENT[31-8*i -: 8]);
      end
      // Every profile: load pulse two cycles after the write
      for (int i = 0; i < 64; i++) begin
         spcr_host_model_i.wr_byte(16'h000e, 8'(i));
         chk_bit(load, 1'b0);
         @(negedge clk_in);
         chk_bit(load, 1'b1);
         chk_val(16'(prof), 16'(i));
         chk_bit(drv, DRIVE[i]);
         @(negedge clk_in);
         chk_bit(load, 1'b0);
      end
      rd_chk(16'h000e, 8'h3f);
      // Restore brings the profile's drive default back
      spcr_host_model_i.wr_byte(16'h0004, 8'h00);
      chk_bit(drv, 1'b0);
      spcr_host_model_i.wr_byte(16'h0000, 8'h20);
      @(negedge clk_in);
      chk_bit(load, 1'b1);
      chk_bit(drv, 1'b1);
      rd_chk(16'h0000, 8'h00);
      // Bit order and upward address stepping
      spcr_host_model_i.wr_byte(16'h0000, 8'h40);
      chk_bit(lsb, 1'b1);
      chk_val(next_addr, 16'h0001);
      rd_chk(16'h0000, 8'h40);
      // Hardware reset and buffered reads keep register values
      spcr_host_model_i.wr_byte(16'h0004, 8'h11);
      chk_bit(hwr, 1'b1);
      chk_bit(rbuf, 1'b1);
      rd_chk(16'h0100, 8'ha5);
      rd_chk(16'h0000, 8'h40);
      chk_val(16'(prof), 16'h003f);
      spcr_host_model_i.wr_byte(16'h0004, 8'h00);
      chk_bit(hwr, 1'b0);
      chk_bit(rbuf, 1'b0);
      rd_chk(16'h0100, 8'h00);
      spcr_host_model_i.wr_byte(16'h0000, 8'h00);
      rd_chk(16'h0010, 8'h00);
      chk_val(next_addr, 16'h000f);
      rd_chk(16'h0000, 8'h00);
      chk_val(next_addr, 16'hffff);
      // Update strobe lasts one cycle and reads back zero
      spcr_host_model_i.wr_byte(16'h0005, 8'h01);
      chk_bit(upd, 1'b1);
      @(negedge clk_in);
      chk_bit(upd, 1'b0);
      rd_chk(16'h0005, 8'h00);
      // Second reset with other strap pins; order, reset and read-target bits must clear, drive takes the strap profile default
      spcr_host_model_i.wr_byte(16'h0000, 8'h40);
      spcr_host_model_i.wr_byte(16'h0004, 8'h13);
      strap = 6'h2a;
      do_reset();
      chk_val(16'(prof), 16'h002a);
      chk_bit(lsb, 1'b0);
      chk_bit(hwr, 1'b0);
      chk_bit(rbuf, 1'b0);
      chk_bit(drv, DRIVE[42]);
      report_and_stop();
   end
endmodule
`default_nettype wire
